// [core/run_ctl_pkg.sv]
package run_ctl_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADR_W = 6;
    localparam int IDX_W = 3;
    localparam int BANK_N = 8;
    localparam int THR_W = 12;
    localparam int CNT_W = 16;
    localparam int PG_CH = 4;
    localparam int PG_CW = 2;
    localparam int WORD_W = 12;
    localparam int CTRL_W = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_CTRL = 6'h00;
    localparam logic [ADR_W-1:0] OFS_STATUS = 6'h04;
    localparam logic [ADR_W-1:0] OFS_WIDX = 6'h08;
    localparam logic [ADR_W-1:0] OFS_WDATA = 6'h0c;
    localparam logic [ADR_W-1:0] OFS_THR = 6'h10;
    localparam logic [ADR_W-1:0] OFS_ADCLIM = 6'h14;
    localparam logic [ADR_W-1:0] OFS_RNGPW = 6'h18;
    localparam logic [ADR_W-1:0] OFS_MINPW = 6'h1c;
    localparam logic [ADR_W-1:0] OFS_SHTIME = 6'h20;
    localparam logic [ADR_W-1:0] OFS_HLDTIME = 6'h24;
    localparam logic [ADR_W-1:0] OFS_PERIOD = 6'h28;
    localparam logic [ADR_W-1:0] OFS_STAGGER = 6'h2c;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ST_PIN_LSB = 4;
    localparam int ST_IDX_LSB = 8;
    localparam int ST_ERR_LSB = 16;
    localparam int ST_WIN_BIT = 19;
    localparam int ST_MOD_LSB = 20;
    localparam int THR_HI_LSB = 16;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [THR_W-1:0] THR_RST = 12'h000;
    localparam logic [2:0] DISABLED_OUTPUT_LEVEL_RST = 3'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ADV_NONE = 2'h0,
        ADV_SHARED = 2'h1,
        ADV_HOLD = 2'h2,
        ADV_THR = 2'h3
    } adv_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_ON = 4'h4,
        ST_OFF = 4'h8
    } chan_e;

    typedef struct packed {
        logic [IDX_W-1:0] start;
        logic [2:0] disabled_output_level;
        logic tmr_mode;
        logic channel_enable_bit;
    } ctrl_s;

    typedef struct packed {
        logic loop;
        adv_e word_advance_select;
        logic [1:0] modulation_type;
        logic init_on;
        logic [2:0] on_drv;
        logic [2:0] off_drv;
    } word_s;

    typedef struct packed {
        logic rng;
        logic minw;
        logic adc;
    } err_s;

    typedef struct packed {
        chan_e state;
        ctrl_s ctrl;
        word_s [BANK_N-1:0] bank;
        logic [BANK_N-1:0] valid;
        logic [IDX_W-1:0] widx;
        logic [IDX_W-1:0] cur;
        word_s word;
        logic [THR_W-1:0] thr_lo;
        logic [THR_W-1:0] thr_hi;
        logic [THR_W-1:0] adc_upper_limit;
        logic [CNT_W-1:0] rng;
        logic [CNT_W-1:0] minw;
        logic [CNT_W-1:0] sh_time;
        logic [CNT_W-1:0] hold_time;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] channel_stagger_delay;
        logic [CNT_W-1:0] tmr_cnt;
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] pw_cnt;
        err_s err;
        logic [2:0] pins;
        logic ack;
        logic [31:0] dat;
    } chan_st_s;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] dly;
        logic act;
        logic [PG_CW-1:0] ch;
        logic [PG_CH-1:0] pulse;
    } pg_st_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_st_s;
endpackage

// [core/pin_sync3.sv]
`timescale 1ns/100ps
module pin_sync3
    import run_ctl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and clean level
    input wire logic pin,
    output logic lvl
);
    sync_st_s q;
    sync_st_s d;

    // ------------------------------------------------------------
    // three stages, level follows once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lvl = q.lvl;
endmodule

// [core/period_pulse_gen.sv]
`timescale 1ns/100ps
module period_pulse_gen
    import run_ctl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // settings
    input wire logic [CNT_W-1:0] interval,
    input wire logic [CNT_W-1:0] stagger,
    // per-channel pulses
    output logic [PG_CH-1:0] pulse
);
    pg_st_s q;
    pg_st_s d;

    // ------------------------------------------------------------
    // interval counter and staggered issue
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.pulse = '0;
        if (interval == CNT_RST) begin
            d.cnt = CNT_RST;
            d.act = 1'b0;
        end else begin
            if (q.cnt >= interval - 1'b1) begin
                d.cnt = CNT_RST;
                d.act = 1'b1;
                d.ch = '0;
                d.dly = CNT_RST;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
            if (q.act) begin
                if (stagger == CNT_RST) begin
                    d.pulse = '1;
                    d.act = 1'b0;
                end else if (q.dly == CNT_RST) begin
                    d.pulse[q.ch] = 1'b1;
                    d.dly = stagger - 1'b1;
                    d.ch = q.ch + 1'b1;
                    if (q.ch == PG_CW'(PG_CH - 1)) begin
                        d.act = 1'b0;
                    end
                end else begin
                    d.dly = q.dly - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pulse = q.pulse;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_period_stopped: assert property (
        interval == CNT_RST |=> q.pulse == '0 && !q.act)
        else $error("period pulse while interval is zero");
    a_stagger_none: assert property (
        q.act && stagger == CNT_RST && interval != CNT_RST |=> &q.pulse)
        else $error("zero stagger did not pulse all channels at once");
endmodule

// [core/reaction_channel_run_control.sv]
`timescale 1ns/100ps
module reaction_channel_run_control
    import run_ctl_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [ADR_W-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // timer window and adc results
    input wire logic TIME_WINDOW,
    input wire logic ADC_VALID,
    input wire logic [THR_W-1:0] ADC_DATA,
    // outputs
    output logic [2:0] CH_PIN,
    output logic [PG_CH-1:0] PERIOD_PULSE
);
    chan_st_s q;
    chan_st_s d;
    logic win;
    logic run_ok;
    logic can_start;
    logic bus_req;
    logic bus_wr;
    logic adc_hi;
    logic turn_off;
    logic turn_on;
    logic adv_evt;
    logic [31:0] wval;
    logic [31:0] status;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // window input and period pulses
    // ------------------------------------------------------------
    pin_sync3 u_win_sync (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .pin(TIME_WINDOW),
        .lvl(win)
    );

    period_pulse_gen u_pgen (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .interval(q.period),
        .stagger(q.channel_stagger_delay),
        .pulse(PERIOD_PULSE)
    );

    // ------------------------------------------------------------
    // run conditions and events
    // ------------------------------------------------------------
    assign run_ok = q.ctrl.channel_enable_bit
        && (!q.ctrl.tmr_mode || win);
    assign can_start = q.valid[q.ctrl.start];
    assign bus_req = CYC_I && STB_I;
    assign bus_wr = bus_req && WE_I && q.ack;
    assign wval = merge(32'h0000_0000, DAT_I, SEL_I);
    assign adc_hi = ADC_VALID && q.adc_upper_limit != THR_RST
        && ADC_DATA > q.adc_upper_limit;
    assign turn_off = q.state == ST_ON && ADC_VALID
        && (ADC_DATA >= q.thr_hi || adc_hi);
    assign turn_on = q.state == ST_OFF && ADC_VALID
        && ADC_DATA < q.thr_lo && !adc_hi;

    always_comb begin
        case (q.word.word_advance_select)
            ADV_SHARED: adv_evt = q.sh_time != CNT_RST
                && q.tmr_cnt == q.sh_time;
            ADV_HOLD: adv_evt = q.hold_time != CNT_RST
                && q.hold_cnt == q.hold_time;
            ADV_THR: adv_evt = turn_off;
            default: adv_evt = 1'b0;
        endcase
    end

    always_comb begin
        status = '0;
        status[3:0] = q.state;
        status[ST_PIN_LSB +: 3] = q.pins;
        status[ST_IDX_LSB +: IDX_W] = q.cur;
        status[ST_ERR_LSB +: 3] = q.err;
        status[ST_WIN_BIT] = win;
        status[ST_MOD_LSB +: 2] = q.word.modulation_type;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        err_s set;
        err_s clr;
        set = '0;
        clr = '0;
        d = q;
        d.ack = bus_req && !q.ack;
        d.dat = '0;

        if (bus_req && !q.ack && !WE_I) begin
            case (ADR_I)
                OFS_CTRL: d.dat = 32'(q.ctrl);
                OFS_STATUS: d.dat = status;
                OFS_WIDX: d.dat = 32'(q.widx);
                OFS_WDATA: d.dat = 32'(q.bank[q.widx]);
                OFS_THR: d.dat = {4'h0, q.thr_hi, 4'h0, q.thr_lo};
                OFS_ADCLIM: d.dat = 32'(q.adc_upper_limit);
                OFS_RNGPW: d.dat = 32'(q.rng);
                OFS_MINPW: d.dat = 32'(q.minw);
                OFS_SHTIME: d.dat = 32'(q.sh_time);
                OFS_HLDTIME: d.dat = 32'(q.hold_time);
                OFS_PERIOD: d.dat = 32'(q.period);
                OFS_STAGGER: d.dat = 32'(q.channel_stagger_delay);
                default: d.dat = '0;
            endcase
        end

        if (bus_wr) begin
            case (ADR_I)
                OFS_CTRL: d.ctrl = CTRL_W'(merge(32'(q.ctrl), DAT_I,
                    SEL_I));
                OFS_STATUS: clr = wval[ST_ERR_LSB +: 3];
                OFS_WIDX: d.widx = IDX_W'(merge(32'(q.widx), DAT_I,
                    SEL_I));
                OFS_WDATA: begin
                    d.bank[q.widx] = WORD_W'(merge(32'(q.bank[q.widx]),
                        DAT_I, SEL_I));
                    d.valid[q.widx] = 1'b1;
                end
                OFS_THR: begin
                    d.thr_lo = THR_W'(merge({20'h0_0000, q.thr_lo}, DAT_I,
                        SEL_I));
                    d.thr_hi = THR_W'(merge({4'h0, q.thr_hi, 16'h0000},
                        DAT_I, SEL_I) >> THR_HI_LSB);
                end
                OFS_ADCLIM: d.adc_upper_limit = THR_W'(merge(
                    32'(q.adc_upper_limit), DAT_I, SEL_I));
                OFS_RNGPW: d.rng = CNT_W'(merge(32'(q.rng), DAT_I,
                    SEL_I));
                OFS_MINPW: d.minw = CNT_W'(merge(32'(q.minw), DAT_I,
                    SEL_I));
                OFS_SHTIME: d.sh_time = CNT_W'(merge(32'(q.sh_time), DAT_I,
                    SEL_I));
                OFS_HLDTIME: d.hold_time = CNT_W'(merge(32'(q.hold_time),
                    DAT_I, SEL_I));
                OFS_PERIOD: d.period = CNT_W'(merge(32'(q.period), DAT_I,
                    SEL_I));
                OFS_STAGGER: d.channel_stagger_delay = CNT_W'(merge(
                    32'(q.channel_stagger_delay), DAT_I, SEL_I));
                default: d.dat = '0;
            endcase
        end

        // per-word timers, saturating
        if (q.tmr_cnt != '1) begin
            d.tmr_cnt = q.tmr_cnt + 1'b1;
        end
        if (q.state == ST_ON && q.hold_cnt != '1) begin
            d.hold_cnt = q.hold_cnt + 1'b1;
        end
        if (q.state == ST_ON && q.pw_cnt != '1) begin
            d.pw_cnt = q.pw_cnt + 1'b1;
        end

        set.adc = adc_hi && q.state != ST_IDLE;
        if (turn_off) begin
            set.minw = q.minw != CNT_RST && q.pw_cnt < q.minw;
            set.rng = q.rng != CNT_RST && q.pw_cnt > q.rng;
            d.pw_cnt = CNT_RST;
        end

        if (!run_ok) begin
            d.state = ST_IDLE;
        end else begin
            case (q.state)
                ST_IDLE: begin
                    if (can_start) begin
                        d.state = ST_FETCH;
                        d.cur = q.ctrl.start;
                    end
                end
                ST_FETCH: begin
                    d.word = q.bank[q.cur];
                    d.state = q.bank[q.cur].init_on ? ST_ON : ST_OFF;
                    d.tmr_cnt = CNT_RST;
                    d.hold_cnt = CNT_RST;
                    d.pw_cnt = CNT_RST;
                end
                ST_ON, ST_OFF: begin
                    if (adv_evt) begin
                        d.state = ST_FETCH;
                        d.cur = q.word.loop ? q.ctrl.start
                            : q.cur + 1'b1;
                    end else if (turn_off) begin
                        d.state = ST_OFF;
                    end else if (turn_on) begin
                        d.state = ST_ON;
                    end
                end
                default: d.state = ST_IDLE;
            endcase
        end

        // an event in the clearing cycle survives
        d.err = (q.err & ~clr) | set;

        case (d.state)
            ST_ON: d.pins = d.word.on_drv;
            ST_OFF: d.pins = d.word.off_drv;
            default: d.pins = d.ctrl.disabled_output_level;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.ctrl.disabled_output_level <= DISABLED_OUTPUT_LEVEL_RST;
        end else begin
            q <= d;
        end
    end

    assign DAT_O = q.dat;
    assign ACK_O = q.ack;
    assign CH_PIN = q.pins;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_loop_adv;
        (q.state == ST_ON || q.state == ST_OFF) && run_ok && adv_evt
            && q.word.loop;
    endsequence

    a_bus_ack: assert property (s_req |=> ACK_O ##1 !ACK_O)
        else $error("ack not a single cycle after request");
    a_sw_start: assert property (
        q.state == ST_IDLE && run_ok && !q.ctrl.tmr_mode && can_start
        |=> q.state == ST_FETCH && q.cur == $past(q.ctrl.start))
        else $error("software start did not fetch start word");
    a_sw_stop: assert property (
        !q.ctrl.channel_enable_bit |=> q.state == ST_IDLE)
        else $error("channel ran while disabled");
    a_window_gate: assert property (
        q.ctrl.tmr_mode && !win |=> q.state == ST_IDLE)
        else $error("timer channel ran outside window");
    a_no_start_word: assert property (
        q.state == ST_IDLE && !can_start |=> q.state == ST_IDLE)
        else $error("started without a stored start word");
    a_adc_skip: assert property (
        q.adc_upper_limit == THR_RST && !q.err.adc |=> !q.err.adc)
        else $error("adc limit check ran with zero limit");
    a_range_skip: assert property (
        q.rng == CNT_RST && !q.err.rng |=> !q.err.rng)
        else $error("range check ran with zero range");
    a_min_skip: assert property (
        q.minw == CNT_RST && !q.err.minw |=> !q.err.minw)
        else $error("minimum check ran with zero minimum");
    a_loop_back: assert property (
        s_loop_adv |=> q.state == ST_FETCH && q.cur == $past(q.ctrl.start))
        else $error("loop word did not return to start");
    a_adv_none: assert property (
        (q.state == ST_ON || q.state == ST_OFF)
        && q.word.word_advance_select == ADV_NONE && run_ok
        |=> q.state != ST_FETCH)
        else $error("advanced with no transition selected");
    a_on_drive: assert property (
        q.state == ST_ON |-> CH_PIN == q.word.on_drv)
        else $error("on drive mismatch");
    a_off_drive: assert property (
        q.state == ST_OFF |-> CH_PIN == q.word.off_drv)
        else $error("off drive mismatch");
    a_idle_level: assert property (
        !run_ok ##1 q.state == ST_IDLE
        |-> CH_PIN == q.ctrl.disabled_output_level)
        else $error("disabled level not driven");
endmodule

// [tb/win_adc_model.sv]
`timescale 1ns/100ps
module win_adc_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic win_on,
    input wire logic slow,
    input wire logic adc_go,
    input wire logic [11:0] adc_val,
    // lines towards the block
    output logic window,
    output logic adc_valid,
    output logic [11:0] adc_data
);
    logic win_q;

    initial begin
        win_q = 1'b0;
        window = 1'b0;
        adc_valid = 1'b0;
        adc_data = 12'h000;
    end

    // slow mode lags the window by one more cycle
    // result bus toggles between strobes so stale data is never valid
    always @(posedge clk) begin
        win_q <= win_on;
        window <= slow ? win_q : win_on;
        adc_valid <= adc_go;
        adc_data <= adc_go ? adc_val : ~adc_data;
    end
endmodule

// [tb/reaction_channel_run_control_tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, got, exp) begin samples_checked++; \
    if ((got) !== (exp)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module reaction_channel_run_control_tb_top
    import run_ctl_pkg::*;
;
    logic clk, rst_n, cyc, stb, we, ack, win_on, slow, adc_go;
    logic window, adc_valid;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [THR_W-1:0] adc_val, adc_data;
    logic [2:0] pins;
    logic [PG_CH-1:0] pulse, seen;
    logic [31:0] exp_q[$], msk_q[$];
    logic [31:0] exp_v, msk_v;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 26990;

    // ------------------------------------------------------------
    // clock, block and far side
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    reaction_channel_run_control DUT (.CORE_CLK(clk), .RST_N(rst_n),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .TIME_WINDOW(window),
        .ADC_VALID(adc_valid), .ADC_DATA(adc_data), .CH_PIN(pins),
        .PERIOD_PULSE(pulse));

    win_adc_model far (.clk(clk), .win_on(win_on), .slow(slow),
        .adc_go(adc_go), .adc_val(adc_val), .window(window),
        .adc_valid(adc_valid), .adc_data(adc_data));

    // ------------------------------------------------------------
    // tasks and read watcher
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb(1'b0, a, $random(seed), 4'hf);
    endtask

    task automatic adc(input logic [11:0] v);
        @(posedge clk);
        adc_go <= 1'b1;
        adc_val <= v;
        @(posedge clk);
        adc_go <= 1'b0;
    endtask

    task automatic wait_pins(input logic [2:0] e);
        int n;
        n = 0;
        while (pins !== e && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK("pins", pins, e)
        if (pins !== e) print_verdict();
    endtask

    task automatic wait_pulse(input logic [PG_CH-1:0] e);
        int n;
        n = 0;
        while (pulse === '0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        `CHK("pulse", pulse, e)
        if (pulse === '0) print_verdict();
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && cyc && !we) begin
            if (exp_q.size() == 0) begin
                `CHK("read_extra", 1'b1, 1'b0)
            end else begin
                exp_v = exp_q.pop_front();
                msk_v = msk_q.pop_front();
                `CHK("read", rdat & msk_v, exp_v)
            end
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {cyc, stb, we, win_on, slow, adc_go, rst_n} = '0;
        adr = '0;
        sel = 4'h0;
        wdat = 32'h0;
        adc_val = 12'h000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 32'h0, 32'hffff_ffff);
        rd(OFS_STATUS, 32'h1, 32'h000f_ffff);
        wr(6'h30, $random(seed));
        rd(6'h30, 32'h0, 32'hffff_ffff);
        wr(OFS_THR, 32'h0800_0400);
        wr(OFS_WIDX, 32'h0);
        wr(OFS_WDATA, 32'h078);
        wr(OFS_CTRL, 32'h14);
        wait_pins(3'h5);
        wb(1'b1, OFS_CTRL, 32'h15, 4'h0);
        repeat (5) @(posedge clk);
        `CHK("pins_nosel", pins, 3'h5)
        wr(OFS_CTRL, 32'h15);
        wait_pins(3'h7);
        adc({1'b1, 11'($random(seed))});
        wait_pins(3'h0);
        adc({2'b00, 10'($random(seed))});
        wait_pins(3'h7);
        rd(OFS_STATUS, 32'h0, 32'h0007_0000);
        wr(OFS_CTRL, 32'h14);
        wait_pins(3'h5);
        slow <= 1'b1;
        wr(OFS_CTRL, 32'h17);
        repeat (10) @(posedge clk);
        `CHK("pins_nowin", pins, 3'h5)
        win_on <= 1'b1;
        wait_pins(3'h7);
        rd(OFS_STATUS, 32'h0008_0000, 32'h0008_0000);
        win_on <= 1'b0;
        wait_pins(3'h5);
        slow <= 1'b0;
        wr(OFS_CTRL, 32'h75);
        repeat (10) @(posedge clk);
        `CHK("pins_nostart", pins, 3'h5)
        rd(OFS_STATUS, 32'h1, 32'hf);
        wr(OFS_SHTIME, 32'd20);
        wr(OFS_HLDTIME, 32'd20);
        wr(OFS_WIDX, 32'h1);
        wr(OFS_WDATA, 32'ha50);
        wr(OFS_WIDX, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CTRL, 32'h14);
            wr(OFS_WDATA, 32'h078 | (c << 9));
            wr(OFS_CTRL, 32'h15);
            wait_pins(3'h7);
            if (c == 0) begin
                repeat (40) @(posedge clk);
                `CHK("pins_stay", pins, 3'h7)
            end else begin
                if (c == 3) adc({1'b1, 11'($random(seed))});
                wait_pins(3'h2);
                wait_pins(3'h7);
            end
        end
        wr(OFS_CTRL, 32'h14);
        wr(OFS_PERIOD, 32'd10);
        wait_pulse(4'hf);
        wr(OFS_PERIOD, 32'd0);
        repeat (12) @(posedge clk);
        seen = '0;
        repeat (60) begin
            @(posedge clk);
            seen = seen | pulse;
        end
        `CHK("pulse_off", seen, 4'h0)
        wr(OFS_STAGGER, 32'd3);
        wr(OFS_PERIOD, 32'd20);
        wait_pulse(4'h1);
        wait_pulse(4'h2);
        print_verdict();
    end
endmodule
